// *** hw/ctqc_pkg.sv ***
package ctqc_pkg;

  // Register byte addresses on the 32-bit Avalon-MM slave
  localparam logic [7:0] BASE_LO_OFS = 8'h00;
  localparam logic [7:0] CFG_HI_OFS  = 8'h04;
  localparam logic [7:0] CTL_LO_OFS  = 8'h08;
  localparam logic [7:0] STA_OFS     = 8'h0C;
  localparam logic [7:0] MAIN_OFS    = 8'h10;
  localparam logic [7:0] SUM_OFS     = 8'h14;
  localparam logic [7:0] BASE_HI_OFS = 8'h18;

  // Configuration register field positions
  localparam int PL_LSB  = 13;
  localparam int DEP_LSB = 8;
  localparam int RTY_LSB = 5;
  localparam int PRI_LSB = 0;

  // Control register bit positions
  localparam int RST_BIT  = 10;
  localparam int REQ_BIT  = 9;
  localparam int INC_BIT  = 8;
  localparam int ATIE_BIT = 4;
  localparam int QEIE_BIT = 2;
  localparam int QNIE_BIT = 0;

  // Status register bit positions
  localparam int IDX_LSB  = 8;
  localparam int ABT_BIT  = 7;
  localparam int LARB_BIT = 6;
  localparam int ERR_BIT  = 5;
  localparam int ATIF_BIT = 4;
  localparam int QEIF_BIT = 2;
  localparam int QNIF_BIT = 0;

  // Main control register
  localparam int MODE_LSB = 0;
  localparam int RLE_BIT  = 3;

  // Reset values and codes
  localparam logic [1:0]  RTY_RST    = 2'h3;
  localparam logic [1:0]  RTY_NONE   = 2'h0;
  localparam logic [1:0]  RTY_THREE  = 2'h1;
  localparam logic [1:0]  TRIES_MAX  = 2'h3;
  localparam logic [2:0]  MODE_RST   = 3'h4;
  localparam logic [2:0]  CFG_MODE   = 3'h4;
  localparam logic [31:0] HDR_BYTES  = 32'h0000_0008;
  localparam logic [15:0] BASE_MASK  = 16'hFFFC;

  typedef struct packed {
    logic [2:0] payload_size_sel;
    logic [4:0] queue_depth_sel;
    logic [1:0] retry_policy;
    logic [4:0] transmit_priority;
  } ctqc_cfg_type;

  // Request toward the protocol engine
  typedef struct packed {
    logic        valid;
    logic [4:0]  slot_index;
    logic [31:0] slot_addr;
    logic [6:0]  payload_bytes;
    logic [4:0]  transmit_priority;
  } ctqc_eng_req_type;

  // Outcome pulses from the protocol engine
  typedef struct packed {
    logic done;
    logic fail;
    logic lost_arb;
    logic bus_err;
  } ctqc_eng_sts_type;

  typedef enum logic [1:0] {
    ST_RUN = 2'b01,
    ST_RST = 2'b10
  } ctqc_state_type;

  function automatic logic [6:0] ctqc_payload_bytes(input logic [2:0] sel);
    case (sel)
      3'h0:    ctqc_payload_bytes = 7'd8;
      3'h1:    ctqc_payload_bytes = 7'd12;
      3'h2:    ctqc_payload_bytes = 7'd16;
      3'h3:    ctqc_payload_bytes = 7'd20;
      3'h4:    ctqc_payload_bytes = 7'd24;
      3'h5:    ctqc_payload_bytes = 7'd32;
      3'h6:    ctqc_payload_bytes = 7'd48;
      default: ctqc_payload_bytes = 7'd64;
    endcase
  endfunction : ctqc_payload_bytes

endpackage : ctqc_pkg

// *** hw/ctqc_top.sv ***
// Contract
// - Base address locates event FIFO; message slots follow directly after it.
// - Base address bits 1:0 read zero and cannot be written.
// - Payload size code selects 8,12,16,20,24,32,48 or 64 bytes.
// - Queue depth is depth field plus one, one to thirty-two slots.
// - Retry field: 00 none, 01 three, 10/11 unlimited; resets to 11.
// - Retry limit applies only when main limit enable bit is set.
// - Priority field ranks queue, 11111 highest, 00000 lowest.
// - Queue reset bit resets queue, then hardware clears it.
// - Send request starts sending; cleared when all queued messages sent.
// - Writing zero to a set send request aborts pending transmission.
// - Head advance bit moves head by exactly one slot.
// - Enable bit gates attempts-exhausted interrupt.
// - Attempts-exhausted flag set by hardware, sticky until software clears.
// - Empty flag one when nothing queued, enable gates it; resets one.
// - Not-full flag one while room remains, enable gates it; resets one.
// - Index field gives zero-based slot to transmit next.
// - Aborted bit one if last message aborted, zero if completed.
// - Aborted bit updates only on completion, abort or queue reset.
// - Lost-arbitration bit shows current message lost arbitration.
// - Error bit shows bus error during current message.
// - Summary bit zero is OR of enabled queue interrupt conditions.
//
// Our own choices: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps
module ctqc_top #(
  parameter logic [31:0] TEF_BYTES = 32'h0000_0000
) (
  input  wire logic                       clk_i,
  input  wire logic                       srst_i,
  input  wire logic [7:0]                 avs_address_i,
  input  wire logic                       avs_read_i,
  input  wire logic                       avs_write_i,
  input  wire logic [31:0]                avs_writedata_i,
  input  wire logic [3:0]                 avs_byteenable_i,
  output logic      [31:0]                avs_readdata_o,
  output logic                            avs_waitrequest_o,
  output ctqc_pkg::ctqc_eng_req_type      eng_req_o,
  output logic                            eng_abort_o,
  input  wire ctqc_pkg::ctqc_eng_sts_type eng_sts_i,
  output logic                            tx_irq_summary_o
);

  ctqc_pkg::ctqc_cfg_type   cfg_r;
  ctqc_pkg::ctqc_state_type state_r;
  logic [31:0] base_r;
  logic [2:0]  mode_r;
  logic        limit_en_r;
  logic        reset_req_r;
  logic        send_req_r;
  logic        ate_ie_r;
  logic        empty_ie_r;
  logic        room_ie_r;
  logic        ate_flag_r;
  logic        aborted_r;
  logic        lost_arb_r;
  logic        bus_err_r;
  logic [4:0]  head_r;
  logic [4:0]  tail_r;
  logic [5:0]  count_r;
  logic [1:0]  tries_r;
  logic        ack_r;
  logic [31:0] rdata_r;
  logic [31:0] rd_val;
  logic [31:0] be_mask;
  logic [31:0] wval;
  logic        wr_go;
  logic        empty;
  logic        room;
  logic [5:0]  depth;
  logic        advance;
  logic        done;
  logic        exhaust;
  logic        sw_abort;
  logic        q_rst;
  logic        irq;

  // Bus handshake: each access waits exactly one cycle
  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_r;
  assign wr_go = avs_write_i & ack_r;
  assign avs_readdata_o = rdata_r;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= (avs_read_i | avs_write_i) & ~ack_r;
    end
  end

  // Occupancy views, live every cycle
  assign depth = {1'b0, cfg_r.queue_depth_sel} + 6'd1;
  assign empty = (count_r == 6'd0);
  assign room  = (count_r < depth);
  assign q_rst = (state_r == ctqc_pkg::ST_RST);

  // Read mux; unmapped addresses read zero
  always_comb begin
    rd_val = 32'h0000_0000;
    case (avs_address_i)
      ctqc_pkg::BASE_LO_OFS: rd_val[15:0] = base_r[15:0];
      ctqc_pkg::BASE_HI_OFS: rd_val[15:0] = base_r[31:16];
      ctqc_pkg::CFG_HI_OFS: begin
        rd_val[ctqc_pkg::PL_LSB +: 3]  = cfg_r.payload_size_sel;
        rd_val[ctqc_pkg::DEP_LSB +: 5] = cfg_r.queue_depth_sel;
        rd_val[ctqc_pkg::RTY_LSB +: 2] = cfg_r.retry_policy;
        rd_val[ctqc_pkg::PRI_LSB +: 5] = cfg_r.transmit_priority;
      end
      ctqc_pkg::CTL_LO_OFS: begin
        rd_val[ctqc_pkg::RST_BIT]  = reset_req_r;
        rd_val[ctqc_pkg::REQ_BIT]  = send_req_r;
        rd_val[ctqc_pkg::ATIE_BIT] = ate_ie_r;
        rd_val[ctqc_pkg::QEIE_BIT] = empty_ie_r;
        rd_val[ctqc_pkg::QNIE_BIT] = room_ie_r;
      end
      ctqc_pkg::STA_OFS: begin
        rd_val[ctqc_pkg::IDX_LSB +: 5] = tail_r;
        rd_val[ctqc_pkg::ABT_BIT]  = aborted_r;
        rd_val[ctqc_pkg::LARB_BIT] = lost_arb_r;
        rd_val[ctqc_pkg::ERR_BIT]  = bus_err_r;
        rd_val[ctqc_pkg::ATIF_BIT] = ate_flag_r;
        rd_val[ctqc_pkg::QEIF_BIT] = empty;
        rd_val[ctqc_pkg::QNIF_BIT] = room;
      end
      ctqc_pkg::MAIN_OFS: begin
        rd_val[ctqc_pkg::MODE_LSB +: 3] = mode_r;
        rd_val[ctqc_pkg::RLE_BIT]       = limit_en_r;
      end
      ctqc_pkg::SUM_OFS: rd_val[0] = irq;
      default: rd_val = 32'h0000_0000;
    endcase
  end

  // Merge write data with current contents by byte lane
  assign be_mask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                    {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
  assign wval = (rd_val & ~be_mask) | (avs_writedata_i & be_mask);

  // Read data captured in the wait cycle, stable at the ack edge
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rdata_r <= 32'h0000_0000;
    end else if (avs_read_i & ~ack_r) begin
      rdata_r <= rd_val;
    end
  end

  // Base address and main control
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      base_r     <= 32'h0000_0000;
      mode_r     <= ctqc_pkg::MODE_RST;
      limit_en_r <= 1'b0;
    end else if (wr_go) begin
      if (avs_address_i == ctqc_pkg::BASE_LO_OFS) begin
        base_r[15:0] <= wval[15:0] & ctqc_pkg::BASE_MASK;
      end
      if (avs_address_i == ctqc_pkg::BASE_HI_OFS) begin
        base_r[31:16] <= wval[15:0];
      end
      if (avs_address_i == ctqc_pkg::MAIN_OFS) begin
        mode_r     <= wval[ctqc_pkg::MODE_LSB +: 3];
        limit_en_r <= wval[ctqc_pkg::RLE_BIT];
      end
    end
  end

  // Queue configuration; geometry is frozen outside configuration mode
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cfg_r.payload_size_sel  <= 3'h0;
      cfg_r.queue_depth_sel   <= 5'h00;
      cfg_r.retry_policy      <= ctqc_pkg::RTY_RST;
      cfg_r.transmit_priority <= 5'h00;
    end else if (wr_go && avs_address_i == ctqc_pkg::CFG_HI_OFS) begin
      if (mode_r == ctqc_pkg::CFG_MODE) begin
        cfg_r.payload_size_sel <= wval[ctqc_pkg::PL_LSB +: 3];
        cfg_r.queue_depth_sel  <= wval[ctqc_pkg::DEP_LSB +: 5];
      end
      cfg_r.retry_policy      <= wval[ctqc_pkg::RTY_LSB +: 2];
      cfg_r.transmit_priority <= wval[ctqc_pkg::PRI_LSB +: 5];
    end
  end

  // Interrupt enables
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ate_ie_r   <= 1'b0;
      empty_ie_r <= 1'b0;
      room_ie_r  <= 1'b0;
    end else if (wr_go && avs_address_i == ctqc_pkg::CTL_LO_OFS) begin
      ate_ie_r   <= wval[ctqc_pkg::ATIE_BIT];
      empty_ie_r <= wval[ctqc_pkg::QEIE_BIT];
      room_ie_r  <= wval[ctqc_pkg::QNIE_BIT];
    end
  end

  // Control write strobes
  assign advance = wr_go && avs_address_i == ctqc_pkg::CTL_LO_OFS
                   && wval[ctqc_pkg::INC_BIT] && room && !q_rst;
  assign sw_abort = wr_go && avs_address_i == ctqc_pkg::CTL_LO_OFS
                    && send_req_r && !wval[ctqc_pkg::REQ_BIT];
  assign done = eng_sts_i.done && send_req_r && !empty && !q_rst;

  // Retry budget: limit applies only with the main enable set
  always_comb begin
    exhaust = 1'b0;
    if (eng_sts_i.fail && send_req_r && !q_rst && limit_en_r) begin
      if (cfg_r.retry_policy == ctqc_pkg::RTY_NONE) begin
        exhaust = 1'b1;
      end else if (cfg_r.retry_policy == ctqc_pkg::RTY_THREE) begin
        exhaust = (tries_r == ctqc_pkg::TRIES_MAX);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      tries_r <= 2'h0;
    end else if (q_rst || done || exhaust || sw_abort) begin
      tries_r <= 2'h0;
    end else if (eng_sts_i.fail && send_req_r && tries_r != ctqc_pkg::TRIES_MAX) begin
      tries_r <= tries_r + 2'h1;
    end
  end

  // Queue reset sequencer: request seen, queue cleared next cycle
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_r     <= ctqc_pkg::ST_RUN;
      reset_req_r <= 1'b0;
    end else begin
      case (state_r)
        ctqc_pkg::ST_RUN: begin
          if (wr_go && avs_address_i == ctqc_pkg::CTL_LO_OFS
              && wval[ctqc_pkg::RST_BIT]) begin
            state_r     <= ctqc_pkg::ST_RST;
            reset_req_r <= 1'b1;
          end
        end
        ctqc_pkg::ST_RST: begin
          state_r     <= ctqc_pkg::ST_RUN;
          reset_req_r <= 1'b0;
        end
        default: begin
          state_r     <= ctqc_pkg::ST_RUN;
          reset_req_r <= 1'b0;
        end
      endcase
    end
  end

  // Head, tail and occupancy; wrap at the configured depth
  always_ff @(posedge clk_i) begin
    if (srst_i || q_rst) begin
      head_r  <= 5'h00;
      tail_r  <= 5'h00;
      count_r <= 6'd0;
    end else begin
      if (advance) begin
        head_r <= (head_r == cfg_r.queue_depth_sel) ? 5'h00 : head_r + 5'h01;
      end
      if (done) begin
        tail_r <= (tail_r == cfg_r.queue_depth_sel) ? 5'h00 : tail_r + 5'h01;
      end
      if (advance && !done) begin
        count_r <= count_r + 6'd1;
      end else if (done && !advance) begin
        count_r <= count_r - 6'd1;
      end
    end
  end

  // Send request: set by software, dropped when drained or aborted
  always_ff @(posedge clk_i) begin
    if (srst_i || q_rst) begin
      send_req_r <= 1'b0;
    end else if (sw_abort || exhaust) begin
      send_req_r <= 1'b0;
    end else if (wr_go && avs_address_i == ctqc_pkg::CTL_LO_OFS
                 && wval[ctqc_pkg::REQ_BIT]) begin
      send_req_r <= 1'b1;
    end else if (done && count_r == 6'd1 && !advance) begin
      send_req_r <= 1'b0;
    end
  end

  // Outcome of the last message
  always_ff @(posedge clk_i) begin
    if (srst_i || q_rst) begin
      aborted_r  <= 1'b0;
      lost_arb_r <= 1'b0;
      bus_err_r  <= 1'b0;
    end else begin
      if (sw_abort || exhaust) begin
        aborted_r <= 1'b1;
      end else if (done) begin
        aborted_r <= 1'b0;
      end
      if (done) begin
        lost_arb_r <= 1'b0;
        bus_err_r  <= 1'b0;
      end else if (eng_sts_i.fail && send_req_r) begin
        lost_arb_r <= eng_sts_i.lost_arb;
        bus_err_r  <= eng_sts_i.bus_err;
      end
    end
  end

  // Exhausted flag: a new event outranks a clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ate_flag_r <= 1'b0;
    end else if (exhaust) begin
      ate_flag_r <= 1'b1;
    end else if (wr_go && avs_address_i == ctqc_pkg::STA_OFS
                 && !wval[ctqc_pkg::ATIF_BIT]) begin
      ate_flag_r <= 1'b0;
    end
  end

  // Summary of enabled conditions
  assign irq = (ate_ie_r & ate_flag_r) | (empty_ie_r & empty)
             | (room_ie_r & room);
  assign tx_irq_summary_o = irq;

  // Engine request, registered; slots follow the event FIFO area
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      eng_req_o   <= '0;
      eng_abort_o <= 1'b0;
    end else begin
      eng_req_o.valid         <= send_req_r & ~empty & ~q_rst;
      eng_req_o.slot_index    <= tail_r;
      eng_req_o.slot_addr     <= base_r + TEF_BYTES
                                 + 32'(tail_r) * (ctqc_pkg::HDR_BYTES
                                 + 32'(ctqc_pkg::ctqc_payload_bytes(
                                   cfg_r.payload_size_sel)));
      eng_req_o.payload_bytes <= ctqc_pkg::ctqc_payload_bytes(cfg_r.payload_size_sel);
      eng_req_o.transmit_priority <= cfg_r.transmit_priority;
      eng_abort_o             <= sw_abort | exhaust;
    end
  end

  // Checks
  AST_BASE_ALIGN: assert property (@(posedge clk_i) disable iff (srst_i)
    base_r[1:0] == 2'h0)
    else $error("base address not word aligned");
  AST_DEPTH_CFG: assert property (@(posedge clk_i) disable iff (srst_i)
    (mode_r != ctqc_pkg::CFG_MODE) |=> $stable(cfg_r.queue_depth_sel))
    else $error("depth changed outside configuration mode");
  AST_RESET_CLEARS: assert property (@(posedge clk_i) disable iff (srst_i)
    $rose(reset_req_r) |=> (!reset_req_r && count_r == 6'd0 && !send_req_r))
    else $error("queue reset did not complete in one cycle");
  AST_DRAIN_CLEARS: assert property (@(posedge clk_i) disable iff (srst_i)
    (done && count_r == 6'd1 && !advance && !sw_abort && !exhaust)
    |=> !send_req_r && empty)
    else $error("send request stayed set after drain");
  AST_ABORT: assert property (@(posedge clk_i) disable iff (srst_i)
    sw_abort |=> !send_req_r && aborted_r && eng_abort_o)
    else $error("abort not honoured");
  AST_ADVANCE_ONE: assert property (@(posedge clk_i) disable iff (srst_i)
    (advance && !done) |=> count_r == $past(count_r) + 6'd1)
    else $error("head advance did not add one message");
  AST_FLAG_STICKY: assert property (@(posedge clk_i) disable iff (srst_i)
    (ate_flag_r && !(wr_go && avs_address_i == ctqc_pkg::STA_OFS
                     && !wval[ctqc_pkg::ATIF_BIT])) |=> ate_flag_r)
    else $error("exhausted flag lost");
  AST_LIMIT_GATED: assert property (@(posedge clk_i) disable iff (srst_i)
    !limit_en_r |-> !exhaust)
    else $error("retry limit applied while disabled");
  AST_ABT_HOLD: assert property (@(posedge clk_i) disable iff (srst_i)
    !(done || sw_abort || exhaust || q_rst) |=> $stable(aborted_r))
    else $error("aborted bit changed without cause");
  AST_SUMMARY: assert property (@(posedge clk_i) disable iff (srst_i)
    (empty_ie_r && count_r == 6'd0) |-> tx_irq_summary_o)
    else $error("summary missed enabled empty condition");
  AST_INDEX_RANGE: assert property (@(posedge clk_i) disable iff (srst_i)
    tail_r <= cfg_r.queue_depth_sel)
    else $error("index beyond depth");

  COV_FILL: cover property (@(posedge clk_i) disable iff (srst_i) !room);
  COV_DRAIN: cover property (@(posedge clk_i) disable iff (srst_i)
    send_req_r ##1 !send_req_r && !aborted_r);
  COV_EXHAUST: cover property (@(posedge clk_i) disable iff (srst_i) exhaust);
  COV_QRESET: cover property (@(posedge clk_i) disable iff (srst_i) q_rst);

endmodule : ctqc_top

// *** tb/ctqc_eng_model.sv ***
`timescale 1ns/1ps
module ctqc_eng_model (
  input  wire logic                       clk_i,
  input  wire logic                       srst_i,
  input  wire ctqc_pkg::ctqc_eng_req_type req_i,
  input  wire logic                       abort_i,
  input  wire logic [1:0]                 mode_i,
  output ctqc_pkg::ctqc_eng_sts_type      sts_o
);
  logic [3:0] gap_r;

  // Mode 0 sends, 1 loses arbitration, 2 hits a bus error, 3 stalls
  always_ff @(posedge clk_i) begin
    if (srst_i || abort_i || !req_i.valid || mode_i == 2'h3) begin
      gap_r <= 4'h0;
      sts_o <= '0;
    end else if (gap_r == 4'h7) begin
      // Gap lets the lagging request catch up, so one message gets one outcome
      gap_r <= 4'h0;
      sts_o <= '{done:     (mode_i == 2'h0),
                 fail:     (mode_i != 2'h0),
                 lost_arb: (mode_i == 2'h1),
                 bus_err:  (mode_i == 2'h2)};
    end else begin
      gap_r <= gap_r + 4'h1;
      sts_o <= '0;
    end
  end
endmodule : ctqc_eng_model

// *** tb/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
  localparam logic [31:0] tef    = 32'h0000_0040;
  localparam logic [7:0]  a_base = ctqc_pkg::BASE_LO_OFS;
  localparam logic [7:0]  a_cfg  = ctqc_pkg::CFG_HI_OFS;
  localparam logic [7:0]  a_ctl  = ctqc_pkg::CTL_LO_OFS;
  localparam logic [7:0]  a_sta  = ctqc_pkg::STA_OFS;
  localparam logic [7:0]  a_main = ctqc_pkg::MAIN_OFS;
  localparam logic [6:0]  pl [8] = '{7'h08, 7'h0C, 7'h10, 7'h14, 7'h18, 7'h20, 7'h30, 7'h40};

  logic                       clk_i            = 1'b0;
  logic                       srst_i           = 1'b1;
  logic [7:0]                 avs_address_i    = 8'h00;
  logic                       avs_read_i       = 1'b0;
  logic                       avs_write_i      = 1'b0;
  logic [31:0]                avs_writedata_i  = 32'h0000_0000;
  logic [3:0]                 avs_byteenable_i = 4'hF;
  logic [31:0]                avs_readdata_o;
  logic                       avs_waitrequest_o;
  ctqc_pkg::ctqc_eng_req_type eng_req_o;
  logic                       eng_abort_o;
  ctqc_pkg::ctqc_eng_sts_type eng_sts_i;
  logic                       tx_irq_summary_o;
  logic [1:0]                 eng_mode         = 2'h3;
  logic [15:0]                q;
  int                         miscompares      = 0;
  int                         checked          = 0;
  int                         aborts           = 0;

  // 200 MHz clock
  always #2.5 clk_i = ~clk_i;

  // Abort pulses seen by the engine side
  always @(posedge clk_i) begin
    if (eng_abort_o === 1'b1) begin
      aborts <= aborts + 1;
    end
  end

  ctqc_top #(.TEF_BYTES(tef)) ctqc_top_inst (
    .clk_i, .srst_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
    .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .eng_req_o, .eng_abort_o,
    .eng_sts_i, .tx_irq_summary_o);

  ctqc_eng_model ctqc_eng_model_inst (.clk_i, .srst_i, .req_i(eng_req_o),
    .abort_i(eng_abort_o), .mode_i(eng_mode), .sts_o(eng_sts_i));

  task automatic finish_test;
    $display("TB: checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : finish_test

  // Register value comparison
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // Engine request comparison, taken mid-cycle once the outputs settle
  task automatic chk_eng(input ctqc_pkg::ctqc_eng_req_type exp);
    @(negedge clk_i);
    checked++;
    if (eng_req_o !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h exp %h", $time, eng_req_o, exp);
    end
    @(posedge clk_i);
  endtask : chk_eng

  // Summary pin is combinational, so look at it mid-cycle
  task automatic irq(input logic e);
    @(negedge clk_i);
    chk({15'h0000, tx_irq_summary_o}, {15'h0000, e});
    @(posedge clk_i);
  endtask : irq

  // One transfer, held until waitrequest is low at a rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
    logic ws;
    int   n;
    n = 0;
    avs_address_i   <= a;
    avs_write_i     <= w;
    avs_read_i      <= !w;
    avs_writedata_i <= {16'h0000, d};
    do begin
      @(negedge clk_i);
      ws = avs_waitrequest_o;
      q  = avs_readdata_o[15:0];
      n++;
      @(posedge clk_i);
    end while (ws !== 1'b0 && n < 16);
    avs_write_i <= 1'b0;
    avs_read_i  <= 1'b0;
    if (ws !== 1'b0) begin
      miscompares++;
      finish_test();
    end
    @(posedge clk_i);
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e);
    bus(1'b0, a, 16'h0000);
    chk(q & m, e);
  endtask : rd

  // Bounded poll until masked bits read clear
  task automatic poll_clr(input logic [15:0] m);
    int n;
    n = 0;
    do begin
      bus(1'b0, a_ctl, 16'h0000);
      n++;
    end while ((q & m) !== 16'h0000 && n < 64);
    chk(q & m, 16'h0000);
    if ((q & m) !== 16'h0000) begin
      finish_test();
    end
  endtask : poll_clr

  task automatic t_reset;
    rd(a_base, 16'hFFFF, 16'h0000);
    rd(a_cfg, 16'hFFFF, 16'h0060);
    rd(a_ctl, 16'hFFFF, 16'h0000);
    rd(a_sta, 16'hFFFF, 16'h0005);
    wr(8'h1C, 16'hFFFF);
    rd(8'h1C, 16'hFFFF, 16'h0000);
    irq(1'b0);
  endtask : t_reset

  task automatic t_base;
    wr(a_base, 16'h1235);
    rd(a_base, 16'hFFFF, 16'h1234);
    wr(8'h18, 16'hA5A5);
    rd(8'h18, 16'hFFFF, 16'hA5A5);
    wr(8'h18, 16'h0000);
  endtask : t_base

  // Four slots filled past full, then the queue is reset
  task automatic t_fill;
    wr(a_cfg, 16'h037F);
    rd(a_cfg, 16'hFFFF, 16'h037F);
    wr(a_ctl, 16'h0005);
    irq(1'b1);
    rd(8'h14, 16'hFFFF, 16'h0001);
    for (int i = 1; i <= 5; i++) begin
      wr(a_ctl, 16'h0105);
      rd(a_sta, 16'hFFFF, (i < 4) ? 16'h0001 : 16'h0000);
    end
    irq(1'b0);
    wr(a_ctl, 16'h0405);
    poll_clr(16'h0400);
    rd(a_sta, 16'hFFFF, 16'h0005);
  endtask : t_fill

  task automatic t_send;
    eng_mode <= 2'h0;
    wr(a_ctl, 16'h0305);
    poll_clr(16'h0200);
    rd(a_sta, 16'hFFFF, 16'h0105);
  endtask : t_send

  // Engine stalls on slot one while every payload code is applied
  task automatic t_layout;
    logic [31:0] ad;
    eng_mode <= 2'h3;
    wr(a_ctl, 16'h0305);
    for (int c = 0; c < 8; c++) begin
      wr(a_cfg, {c[2:0], 13'h037F});
      ad = 32'h0000_1234 + tef + 32'h0000_0008 + 32'(pl[c]);
      chk_eng('{1'b1, 5'h01, ad, pl[c], 5'h1F});
    end
    wr(a_ctl, 16'h0005);
    rd(a_sta, 16'h0080, 16'h0080);
    rd(a_ctl, 16'h0200, 16'h0000);
    chk(16'(aborts), 16'h0001);
  endtask : t_layout

  // Failing engine until the retry policy gives up
  task automatic t_exhaust(input logic [1:0] pol, input logic [1:0] md, input logic [15:0] st);
    wr(a_ctl, 16'h0405);
    poll_clr(16'h0400);
    rd(a_sta, 16'hFFFF, 16'h0005);
    wr(a_cfg, {9'h000, pol, 5'h00});
    rd(a_cfg, 16'hFFFF, {9'h1C6, pol, 5'h00});
    eng_mode <= md;
    wr(a_ctl, 16'h0310);
    poll_clr(16'h0200);
    rd(a_sta, 16'hFFFF, st);
    irq(1'b1);
    wr(a_sta, 16'h0000);
    rd(a_sta, 16'h0010, 16'h0000);
    irq(1'b0);
  endtask : t_exhaust

  // With the limit disabled the queue keeps retrying
  task automatic t_nolimit;
    wr(a_main, 16'h0000);
    wr(a_ctl, 16'h0310);
    repeat (60) @(posedge clk_i);
    rd(a_ctl, 16'h0200, 16'h0200);
    rd(a_sta, 16'h0010, 16'h0000);
  endtask : t_nolimit

  // Main sequence
  initial begin
    repeat (16) @(posedge clk_i);
    srst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_base();
    t_fill();
    t_send();
    t_layout();
    wr(a_main, 16'h0008);
    t_exhaust(2'h1, 2'h1, 16'h00D1);
    t_exhaust(2'h0, 2'h2, 16'h00B1);
    chk(16'(aborts), 16'h0003);
    t_nolimit();
    finish_test();
  end
endmodule : tb_top
